// [hdl/pfsw_ctrl.sv]
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/10ps
// ********************************************************************
// program flash self write controller
// ********************************************************************
// Overview of operation
// R1: program memory is rows of 32 words aligned on low five bits zero
// R2: erase or program inside a write-protected segment is refused
// R3: pending data sits in 14-bit latches filled only via data regs
// R4: processor loads address, clears config select, sets program select
// R5: array read uses second cycle after read strobe, slot forced nop
// R6: fetched word appears in data pair next cycle and is held
// R7: software places two nops after setting the read strobe
// R8: reads are allowed whatever the code-protect bit says
// R9: erase setup: row address, program select, erase select, permit
// R10: erase or commit needs key 55h then AAh then write strobe
// R11: row erase select clears when a row erase finishes
// R12: erase takes two setup cycles then stalls processor about 2 ms
// R13: processor resumes at third instruction after the strobe
// R14: programming never erases first
// R15: one latch block per commit, aligned, never spanning blocks
// R16: after a commit every latch returns to 3FFF
// R17: latch load only set: strobe loads one latch, no stall
// R18: latch load only clear: load last latch then program whole block
// R19: commit takes two setup cycles then stalls about 2 ms
// R20: processor fills latches with address, data, unlock, strobe
// R21: software keeps interrupts out of the unlock sequence
// R22: strobes are set-only by software, cleared by hardware
// R23: write strobe cannot be set unless write permit is set
// R24: write abort flag set when reset interrupts an operation
// R25: config space select steers access to id and config region
// R26: reset clears control bits and fills latches with 3FFF; the write abort bit instead loads the busy level caught before reset
module pfsw_ctrl #(
    parameter int STALL_CYCLES = pfsw_pkg::STALL_CYCLES,
    parameter int ADDR_WIDTH = 15
) (
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic CODE_PROTECT_I,
    input wire logic INSTR_DONE_I,
    output logic CPU_STALL_O,
    output logic FORCE_NOP_O,
    output logic [ADDR_WIDTH-1:0] ARRAY_ADDR_O,
    output logic [13:0] ARRAY_WDATA_O,
    input wire logic [13:0] ARRAY_RDATA_I,
    output logic ARRAY_READ_O,
    output logic ARRAY_ERASE_O,
    output logic ARRAY_PROGRAM_O,
    output logic ARRAY_CONFIG_O
);
    initial begin
        if (ADDR_WIDTH < 6 || ADDR_WIDTH > 15 ||
            STALL_CYCLES < pfsw_pkg::ROW_WORDS ||
            STALL_CYCLES >= (1 << 23)) begin
            $error("pfsw_ctrl: unsupported parameter values");
        end
    end

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_READ = 5'b00010,
        ST_SETUP = 5'b00100,
        ST_STALL = 5'b01000,
        ST_RESUME = 5'b10000
    } pfsw_state_t;

    // ****************************************************************
    // registers
    // ****************************************************************
    pfsw_state_t state;
    logic [7:0] ctrl;
    logic [7:0] data_low;
    logic [5:0] data_high;
    logic [7:0] addr_low;
    logic [6:0] addr_high;
    logic [1:0] protect;
    logic [1:0] key_stage;
    logic [22:0] count;
    logic erase_op;
    // two-state so a power-up reset reads as no abort
    bit busy_at_reset;
    logic [13:0] latch [0:31];
    logic [4:0] block_idx;

    // ****************************************************************
    // decode
    // ****************************************************************
    wire acc = PSEL_I && PENABLE_I;
    wire wr = acc && PWRITE_I;
    wire wr_ctrl = wr && (PADDR_I == pfsw_pkg::ADDR_ACCESS_CTRL);
    wire wr_key = wr && (PADDR_I == pfsw_pkg::ADDR_UNLOCK_KEY);
    wire wr_dl = wr && (PADDR_I == pfsw_pkg::ADDR_DATA_LOW);
    wire wr_dh = wr && (PADDR_I == pfsw_pkg::ADDR_DATA_HIGH);
    wire wr_al = wr && (PADDR_I == pfsw_pkg::ADDR_ADDRESS_LOW);
    wire wr_ah = wr && (PADDR_I == pfsw_pkg::ADDR_ADDRESS_HIGH);
    wire wr_pr = wr && (PADDR_I == pfsw_pkg::ADDR_PROTECT);
    wire mapped = (PADDR_I == pfsw_pkg::ADDR_ACCESS_CTRL) ||
        (PADDR_I == pfsw_pkg::ADDR_UNLOCK_KEY) ||
        (PADDR_I == pfsw_pkg::ADDR_DATA_LOW) ||
        (PADDR_I == pfsw_pkg::ADDR_DATA_HIGH) ||
        (PADDR_I == pfsw_pkg::ADDR_ADDRESS_LOW) ||
        (PADDR_I == pfsw_pkg::ADDR_ADDRESS_HIGH) ||
        (PADDR_I == pfsw_pkg::ADDR_PROTECT);
    wire idle = (state == pfsw_state_t'(ST_IDLE));
    wire [14:0] full_addr = {addr_high, addr_low};
    wire [ADDR_WIDTH-1:0] cur_addr = full_addr[ADDR_WIDTH-1:0];
    wire prog_sel = ctrl[pfsw_pkg::BIT_PROGRAM_SPACE];
    wire cfg_sel = ctrl[pfsw_pkg::BIT_CONFIG_SPACE];
    wire permit = ctrl[pfsw_pkg::BIT_WRITE_PERMIT];
    wire llo = ctrl[pfsw_pkg::BIT_LATCH_LOAD_ONLY];
    wire erase_sel = ctrl[pfsw_pkg::BIT_ROW_ERASE];
    // protect 3: none, 2: lower quarter, 1: lower half, 0: all
    function automatic logic is_protected(input logic [1:0] p,
                                          input logic [14:0] a);
        logic [1:0] top;
        top = a[ADDR_WIDTH-1 -: 2];
        case (p)
            2'h3: is_protected = 1'b0;
            2'h2: is_protected = (top == 2'h0);
            2'h1: is_protected = !top[1];
            default: is_protected = 1'b1;
        endcase
    endfunction
    wire prot_hit = is_protected(protect, full_addr) && !cfg_sel; // R2
    // read strobe only acts while idle
    wire rd_start = wr_ctrl && PWDATA_I[pfsw_pkg::BIT_READ_STROBE] &&
        idle && prog_sel; // R4 R8
    // write strobe honoured only with permit, armed key and idle
    wire wr_start = wr_ctrl && PWDATA_I[pfsw_pkg::BIT_WRITE_STROBE] &&
        permit && idle && (key_stage == 2'd2) && prog_sel; // R10 R23
    wire wr_allowed = wr_start && !prot_hit; // R2
    wire do_load = wr_allowed && !erase_sel; // R3
    wire do_commit = wr_allowed && !erase_sel && !llo; // R18
    wire do_erase = wr_allowed && erase_sel; // R9
    wire [4:0] slot = addr_low[4:0];
    wire [ADDR_WIDTH-1:0] row_base = {cur_addr[ADDR_WIDTH-1:5], 5'h00};
    wire stall_end = (state == pfsw_state_t'(ST_STALL)) &&
        (count == 23'(STALL_CYCLES - 1));
    wire [7:0] ctrl_rd = ctrl;
    wire [31:0] next_rdata =
        (PADDR_I == pfsw_pkg::ADDR_ACCESS_CTRL) ? {24'h0000_00, ctrl_rd} :
        (PADDR_I == pfsw_pkg::ADDR_DATA_LOW) ? {24'h0000_00, data_low} :
        (PADDR_I == pfsw_pkg::ADDR_DATA_HIGH) ? {26'h000_0000, data_high} :
        (PADDR_I == pfsw_pkg::ADDR_ADDRESS_LOW) ? {24'h0000_00, addr_low} :
        (PADDR_I == pfsw_pkg::ADDR_ADDRESS_HIGH) ? {25'h000_0000, addr_high} :
        (PADDR_I == pfsw_pkg::ADDR_PROTECT) ? {30'h0000_0000, protect} :
        32'h0000_0000;

    // ****************************************************************
    // apb answer: zero wait states, error on unmapped
    // ****************************************************************
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            PRDATA_O <= 32'h0000_0000;
            PREADY_O <= 1'b0;
            PSLVERR_O <= 1'b0;
        end else begin
            PREADY_O <= PSEL_I && !PENABLE_I;
            PSLVERR_O <= PSEL_I && !PENABLE_I && !mapped;
            PRDATA_O <= (PSEL_I && !PENABLE_I && !PWRITE_I) ?
                next_rdata : 32'h0000_0000;
        end
    end
    // access phase committed when pready sampled high
    wire take = acc && PREADY_O;

    // ****************************************************************
    // unlock key tracking
    // ****************************************************************
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            key_stage <= 2'd0;
        end else if (take && wr_key) begin
            if (PWDATA_I[7:0] == pfsw_pkg::KEY_FIRST) begin
                key_stage <= 2'd1;
            end else if (PWDATA_I[7:0] == pfsw_pkg::KEY_SECOND &&
                         key_stage == 2'd1) begin
                key_stage <= 2'd2;
            end else begin
                key_stage <= 2'd0;
            end
        end else if (take) begin
            key_stage <= 2'd0; // R10
        end
    end

    // ****************************************************************
    // control register
    // ****************************************************************
    wire [7:0] ctrl_sw = {PWDATA_I[7:4] & 4'hF, ctrl[3], PWDATA_I[2],
        ctrl[1:0]};
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            ctrl <= {4'h0, busy_at_reset, 3'h0}; // R24 R26
        end else begin
            if (take && wr_ctrl) begin
                ctrl[7:2] <= ctrl_sw[7:2];
                if (PWDATA_I[pfsw_pkg::BIT_WRITE_ABORT] == 1'b0) begin
                    ctrl[pfsw_pkg::BIT_WRITE_ABORT] <= 1'b0;
                end
                if (!idle) begin
                    ctrl[pfsw_pkg::BIT_ROW_ERASE] <= erase_sel;
                end
            end
            if (take && rd_start) begin
                ctrl[pfsw_pkg::BIT_READ_STROBE] <= 1'b1; // R22
            end
            if (take && wr_allowed && (do_erase || do_commit)) begin
                ctrl[pfsw_pkg::BIT_WRITE_STROBE] <= 1'b1; // R22 R23
            end
            if (state == pfsw_state_t'(ST_READ) && count == 23'd1) begin
                ctrl[pfsw_pkg::BIT_READ_STROBE] <= 1'b0; // R22
            end
            if (stall_end) begin
                ctrl[pfsw_pkg::BIT_WRITE_STROBE] <= 1'b0; // R22
                if (erase_op) begin
                    ctrl[pfsw_pkg::BIT_ROW_ERASE] <= 1'b0; // R11
                end
            end
        end
    end

    // busy level caught outside reset for the abort flag
    always_ff @(posedge CLK_I) begin
        busy_at_reset <= SYS_RST_I ? busy_at_reset :
            (state == pfsw_state_t'(ST_STALL) ||
             state == pfsw_state_t'(ST_SETUP)); // R24
    end

    // ****************************************************************
    // address, data, protection registers
    // ****************************************************************
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            addr_low <= 8'h00;
            addr_high <= 7'h00;
            data_low <= 8'h00;
            data_high <= 6'h00;
            protect <= pfsw_pkg::PROTECT_RESET;
        end else begin
            if (take && wr_al) begin
                addr_low <= PWDATA_I[7:0];
            end
            if (take && wr_ah) begin
                addr_high <= PWDATA_I[6:0];
            end
            if (take && wr_pr) begin
                protect <= PWDATA_I[1:0];
            end
            if (state == pfsw_state_t'(ST_READ) && count == 23'd1) begin
                data_low <= ARRAY_RDATA_I[7:0]; // R6
                data_high <= ARRAY_RDATA_I[13:8]; // R6
            end else begin
                if (take && wr_dl) begin
                    data_low <= PWDATA_I[7:0];
                end
                if (take && wr_dh) begin
                    data_high <= PWDATA_I[5:0];
                end
            end
        end
    end

    // ****************************************************************
    // write latches
    // ****************************************************************
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I || stall_end && !erase_op) begin
            for (int i = 0; i < pfsw_pkg::ROW_WORDS; i++) begin
                latch[i] <= pfsw_pkg::LATCH_ERASED; // R16 R26
            end
        end else if (take && do_load) begin
            latch[slot] <= {data_high, data_low}; // R3 R17
        end
    end

    // ****************************************************************
    // sequencer
    // ****************************************************************
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            state <= ST_IDLE;
            count <= 23'd0;
            erase_op <= 1'b0;
            block_idx <= 5'd0;
            CPU_STALL_O <= 1'b0;
            FORCE_NOP_O <= 1'b0;
            ARRAY_ADDR_O <= '0;
            ARRAY_WDATA_O <= 14'h0000;
            ARRAY_READ_O <= 1'b0;
            ARRAY_ERASE_O <= 1'b0;
            ARRAY_PROGRAM_O <= 1'b0;
            ARRAY_CONFIG_O <= 1'b0;
        end else begin
            ARRAY_READ_O <= 1'b0;
            ARRAY_ERASE_O <= 1'b0;
            ARRAY_PROGRAM_O <= 1'b0;
            FORCE_NOP_O <= 1'b0;
            case (state)
                ST_IDLE: begin
                    count <= 23'd0;
                    if (take && rd_start) begin
                        state <= ST_READ;
                        ARRAY_ADDR_O <= cur_addr;
                        ARRAY_CONFIG_O <= cfg_sel; // R25
                    end else if (take && (do_erase || do_commit)) begin
                        state <= ST_SETUP; // R17
                        erase_op <= do_erase;
                        ARRAY_ADDR_O <= row_base; // R1 R15
                        ARRAY_CONFIG_O <= cfg_sel; // R25
                    end
                end
                ST_READ: begin
                    // data pair loads once, then later writes stick
                    if (count != 23'd0) begin
                        state <= ST_IDLE; // R6
                    end else if (INSTR_DONE_I) begin
                        count <= 23'd1;
                        ARRAY_READ_O <= 1'b1; // R5
                        FORCE_NOP_O <= 1'b1; // R5
                    end
                end
                ST_SETUP: begin
                    if (INSTR_DONE_I) begin
                        count <= count + 23'd1;
                        if (count == 23'(pfsw_pkg::SETUP_CYCLES - 1)) begin
                            state <= ST_STALL; // R12 R19
                            count <= 23'd0;
                            CPU_STALL_O <= 1'b1;
                            ARRAY_ERASE_O <= erase_op; // R14
                            block_idx <= 5'd0;
                        end
                    end
                end
                ST_STALL: begin
                    count <= count + 23'd1;
                    if (!erase_op && count < 23'(pfsw_pkg::ROW_WORDS)) begin
                        ARRAY_PROGRAM_O <= 1'b1; // R15 R18
                        ARRAY_ADDR_O <= row_base | ADDR_WIDTH'(block_idx);
                        ARRAY_WDATA_O <= latch[block_idx];
                        block_idx <= block_idx + 5'd1;
                    end
                    if (stall_end) begin
                        state <= ST_RESUME;
                        CPU_STALL_O <= 1'b0; // R13
                    end
                end
                ST_RESUME: begin
                    state <= ST_IDLE; // R13
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    AST_STROBE_NEEDS_PERMIT: assert property (@(posedge CLK_I) // R23
        disable iff (SYS_RST_I) $rose(ctrl[pfsw_pkg::BIT_WRITE_STROBE])
        |-> $past(permit))
        else $error("write strobe set without permit");
    AST_KEY_REQUIRED: assert property (@(posedge CLK_I) // R10
        disable iff (SYS_RST_I) (idle ##1 state == ST_SETUP)
        |-> $past(key_stage) == 2'd2)
        else $error("operation started without unlock key");
    AST_STALL_AFTER_SETUP: assert property (@(posedge CLK_I) // R12
        disable iff (SYS_RST_I) $rose(CPU_STALL_O)
        |-> $past(state) == ST_SETUP)
        else $error("stall did not follow setup");
    AST_ERASE_CLEARS: assert property (@(posedge CLK_I) // R11
        disable iff (SYS_RST_I) (stall_end && erase_op)
        |=> !ctrl[pfsw_pkg::BIT_ROW_ERASE])
        else $error("row erase bit not cleared");
    AST_NO_STALL_ON_LOAD: assert property (@(posedge CLK_I) // R17
        disable iff (SYS_RST_I) (take && do_load && llo)
        |=> state == ST_IDLE)
        else $error("latch load left idle");
    AST_PROTECT: assert property (@(posedge CLK_I) // R2
        disable iff (SYS_RST_I) (take && wr_start && prot_hit)
        |=> idle)
        else $error("protected address accepted");
    AST_READ_SLOT: assert property (@(posedge CLK_I) // R5
        disable iff (SYS_RST_I) ARRAY_READ_O |-> FORCE_NOP_O)
        else $error("read slot not forced nop");
    AST_LATCH_RESET: assert property (@(posedge CLK_I) // R16
        disable iff (SYS_RST_I) (stall_end && !erase_op)
        |=> latch[0] == pfsw_pkg::LATCH_ERASED)
        else $error("latches not reset after commit");
    COV_READ: cover property (@(posedge CLK_I) ARRAY_READ_O);
    COV_READ_LOCKED: cover property (@(posedge CLK_I) // R8
        ARRAY_READ_O && CODE_PROTECT_I);
    COV_ERASE: cover property (@(posedge CLK_I) ARRAY_ERASE_O);
    COV_COMMIT: cover property (@(posedge CLK_I) ARRAY_PROGRAM_O);
endmodule

// [hdl/pfsw_pkg.sv]
package pfsw_pkg;
    // ****************************************************************
    // register offsets (byte addresses on apb)
    // ****************************************************************
    localparam logic [7:0] ADDR_ACCESS_CTRL = 8'h00;
    localparam logic [7:0] ADDR_UNLOCK_KEY = 8'h04;
    localparam logic [7:0] ADDR_DATA_LOW = 8'h08;
    localparam logic [7:0] ADDR_DATA_HIGH = 8'h0C;
    localparam logic [7:0] ADDR_ADDRESS_LOW = 8'h10;
    localparam logic [7:0] ADDR_ADDRESS_HIGH = 8'h14;
    localparam logic [7:0] ADDR_PROTECT = 8'h18;
    // ****************************************************************
    // control register field positions
    // ****************************************************************
    localparam int BIT_READ_STROBE = 0;
    localparam int BIT_WRITE_STROBE = 1;
    localparam int BIT_WRITE_PERMIT = 2;
    localparam int BIT_WRITE_ABORT = 3;
    localparam int BIT_ROW_ERASE = 4;
    localparam int BIT_LATCH_LOAD_ONLY = 5;
    localparam int BIT_CONFIG_SPACE = 6;
    localparam int BIT_PROGRAM_SPACE = 7;
    // ****************************************************************
    // values and timing
    // ****************************************************************
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;
    localparam logic [13:0] LATCH_ERASED = 14'h3FFF;
    localparam logic [1:0] PROTECT_RESET = 2'h3;
    localparam int ROW_WORDS = 32;
    localparam int SETUP_CYCLES = 2;
    localparam int CLK_MHZ = 250;
    localparam int STALL_TIME_MS = 2;
    localparam int STALL_CYCLES = STALL_TIME_MS * CLK_MHZ * 1000;
    localparam int READ_DELAY = 2;
endpackage

// [testbench/pfsw_cpu_model.sv]
`timescale 1ns/10ps
// ********************************************************************
// processor pacing and flash array model
// ********************************************************************
module pfsw_cpu_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [2:0] gap_i,
    input wire logic stall_i,
    input wire logic [14:0] addr_i,
    input wire logic [13:0] wdata_i,
    input wire logic erase_i,
    input wire logic program_i,
    output logic instr_done_o,
    output logic [13:0] rdata_o
);
    logic [13:0] mem [0:32767];
    logic [2:0] cnt;
    assign rdata_o = mem[addr_i];
    initial begin
        for (int i = 0; i < 32768; i++) begin
            mem[i] = 14'(i) ^ 14'h2A5A;
        end
    end
    // one instruction per gap, none while halted
    always @(posedge clk_i) begin
        cnt <= (rst_i || stall_i || cnt >= gap_i) ? 3'h0 : cnt + 3'h1;
        instr_done_o <= !rst_i && !stall_i && cnt >= gap_i;
    end
    always @(posedge clk_i) begin
        if (erase_i) begin
            for (int i = 0; i < 32; i++) begin
                mem[{addr_i[14:5], 5'(i)}] <= 14'h3FFF;
            end
        end
        if (program_i) begin
            mem[addr_i] <= mem[addr_i] & wdata_i;
        end
    end
endmodule

// [testbench/tb_program_flash_self_write_controller.sv]
`timescale 1ns/10ps
`define CHK(g, e) begin \
    tests_run++; \
    if ((g) !== (e)) begin \
        errors++; \
        $display("unexpected %0t: %0h vs %0h", $time, g, e); \
    end \
end
// ********************************************************************
// self checking bench
// ********************************************************************
module tb_program_flash_self_write_controller;
    localparam int STALL = 64;
    localparam logic [14:0] EB = 15'h4000;
    localparam logic [7:0] a_ctl = pfsw_pkg::ADDR_ACCESS_CTRL;
    localparam logic [7:0] a_key = pfsw_pkg::ADDR_UNLOCK_KEY;
    logic clk, rst, psel, pen, pwr, pready, pslverr, serr, cp;
    logic instr, stall, fnop, ard, aer, apg, acfg;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [14:0] aaddr, a;
    logic [13:0] awd, ardata, w;
    logic [13:0] dat [0:3];
    logic [2:0] gap;
    logic [15:0] seed = 16'h0011;
    int errors = 0, tests_run = 0, scnt = 0, slen = 0, nops = 0, n0;
    pfsw_ctrl #(.STALL_CYCLES(STALL)) dut_u (
        .CLK_I(clk), .SYS_RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
        .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .CODE_PROTECT_I(cp), .INSTR_DONE_I(instr), .CPU_STALL_O(stall),
        .FORCE_NOP_O(fnop), .ARRAY_ADDR_O(aaddr), .ARRAY_WDATA_O(awd),
        .ARRAY_RDATA_I(ardata), .ARRAY_READ_O(ard), .ARRAY_ERASE_O(aer),
        .ARRAY_PROGRAM_O(apg), .ARRAY_CONFIG_O(acfg));
    pfsw_cpu_model cpu_u (
        .clk_i(clk), .rst_i(rst), .gap_i(gap), .stall_i(stall),
        .addr_i(aaddr), .wdata_i(awd), .erase_i(aer), .program_i(apg),
        .instr_done_o(instr), .rdata_o(ardata));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        nops <= nops + int'(fnop === 1'b1);
        if (stall === 1'b1) begin
            scnt <= scnt + 1;
        end else if (scnt != 0) begin
            slen <= scnt;
            scnt <= 0;
        end
    end
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [13:0] init_word(input logic [14:0] x);
        return 14'(x) ^ 14'h2A5A;
    endfunction
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic fail();
        errors++;
        print_verdict();
    endtask
    task automatic apb(input logic wr_en, input logic [7:0] ad,
                       input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= wr_en;
        paddr <= ad;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) fail();
        r = prdata;
        serr = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] ad);
        apb(1'b0, ad, 32'h0000_0000);
    endtask
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        apb(1'b1, ad, d);
    endtask
    task automatic poll(input int b);
        int n;
        n = 0;
        do begin
            rd(a_ctl);
            n++;
        end while (r[b] !== 1'b0 && n < 400);
        if (n >= 400) fail();
    endtask
    task automatic seta(input logic [14:0] x);
        wr(pfsw_pkg::ADDR_ADDRESS_LOW, {24'h00_0000, x[7:0]});
        wr(pfsw_pkg::ADDR_ADDRESS_HIGH, {25'h000_0000, x[14:8]});
    endtask
    task automatic setd(input logic [13:0] x);
        wr(pfsw_pkg::ADDR_DATA_LOW, {24'h00_0000, x[7:0]});
        wr(pfsw_pkg::ADDR_DATA_HIGH, {26'h000_0000, x[13:8]});
    endtask
    task automatic go(input logic [7:0] c);
        wr(a_ctl, {24'h00_0000, c & 8'hFC});
        wr(a_key, {24'h00_0000, pfsw_pkg::KEY_FIRST});
        wr(a_key, {24'h00_0000, pfsw_pkg::KEY_SECOND});
        wr(a_ctl, {24'h00_0000, c});
    endtask
    task automatic rdword(input logic [14:0] x);
        seta(x);
        wr(a_ctl, 32'h0000_0080);
        wr(a_ctl, 32'h0000_0081);
        poll(0);
        rd(pfsw_pkg::ADDR_DATA_LOW);
        w[7:0] = r[7:0];
        rd(pfsw_pkg::ADDR_DATA_HIGH);
        w[13:8] = r[5:0];
    endtask
    initial begin
        {psel, pen, pwr, cp} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        gap = 3'h1;
        rst = 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(a_ctl);
        `CHK(r[7:0], 8'h00)
        rd(pfsw_pkg::ADDR_PROTECT);
        `CHK(r[1:0], pfsw_pkg::PROTECT_RESET)
        rd(8'hFC);
        `CHK(serr, 1'b1)
        $display("done reset");
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            gap <= seed[2:0];
            cp <= seed[3];
            a = (i == 0) ? 15'h7FFF : seed[14:0];
            n0 = nops;
            rdword(a);
            `CHK(w, init_word(a))
            `CHK(nops - n0, 1)
        end
        $display("done read");
        seta(EB);
        go(8'h92);
        rd(a_ctl);
        `CHK(r[1], 1'b0)
        wr(a_ctl, 32'h0000_0094);
        wr(a_key, 32'h0000_0055);
        wr(pfsw_pkg::ADDR_DATA_LOW, 32'h0000_0000);
        wr(a_key, 32'h0000_00AA);
        wr(a_ctl, 32'h0000_0096);
        rd(a_ctl);
        `CHK(r[1], 1'b0)
        wr(pfsw_pkg::ADDR_PROTECT, 32'h0000_0000);
        go(8'h96);
        rd(a_ctl);
        `CHK(r[1], 1'b0)
        wr(pfsw_pkg::ADDR_PROTECT, 32'h0000_0003);
        rdword(EB);
        `CHK(w, init_word(EB))
        $display("done refusals");
        seta(EB);
        slen = 0;
        go(8'h96);
        poll(4);
        `CHK(slen, STALL)
        `CHK(r[1], 1'b0)
        rdword(EB + 15'h001F);
        `CHK(w, 14'h3FFF)
        rdword(EB + 15'h0020);
        `CHK(w, init_word(EB + 15'h0020))
        $display("done erase");
        slen = 0;
        for (int k = 0; k < 4; k++) begin
            seed = lfsr(seed);
            dat[k] = seed[13:0];
            gap <= seed[15:13];
            seta(EB + 15'(k));
            setd(dat[k]);
            go(8'hA6);
        end
        `CHK(slen, 0)
        rdword(EB);
        `CHK(w, 14'h3FFF)
        seta(EB + 15'h001F);
        setd(14'h0F0F);
        go(8'h86);
        poll(1);
        `CHK(slen, STALL)
        for (int k = 0; k < 4; k++) begin
            rdword(EB + 15'(k));
            `CHK(w, dat[k])
        end
        rdword(EB + 15'h001F);
        `CHK(w, 14'h0F0F)
        rdword(EB + 15'h000A);
        `CHK(w, 14'h3FFF)
        rdword(EB + 15'h0020);
        `CHK(w, init_word(EB + 15'h0020))
        seta(EB);
        go(8'h96);
        poll(4);
        seta(EB + 15'h0005);
        setd(14'h1234);
        go(8'h86);
        poll(1);
        rdword(EB);
        `CHK(w, 14'h3FFF)
        rdword(EB + 15'h0005);
        `CHK(w, 14'h1234)
        $display("done commit");
        go(8'h96);
        n0 = 0;
        while (stall !== 1'b1 && n0 < 100) begin
            @(posedge clk);
            n0++;
        end
        if (n0 >= 100) fail();
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(a_ctl);
        `CHK(r[3], 1'b1)
        `CHK(r[2:0], 3'h0)
        wr(a_ctl, 32'h0000_0000);
        rd(a_ctl);
        `CHK(r[3], 1'b0)
        wr(a_ctl, 32'h0000_00C0);
        wr(a_ctl, 32'h0000_00C1);
        `CHK(acfg, 1'b1)
        $display("done abort and config");
        print_verdict();
    end
endmodule
